//--- core_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_side_model
(
   // clock
   input  wire logic        clk,
   // read ports of the block
   input  wire logic        special_rd,
   input  wire logic [7:0]  special_addr,
   output logic [7:0]       special_rdata,
   input  wire logic        code_rd,
   input  wire logic [13:0] code_addr,
   output logic [7:0]       code_rdata,
   input  wire logic        flash_rd,
   input  wire logic [6:0]  flash_addr,
   output logic [7:0]       flash_rdata
);
   // unselected lines toggle, so a stale read never passes for data
   logic [7:0] junk_r = 8'h3C;
   always @(posedge clk)
   begin
      junk_r <= ~junk_r;
   end
   assign special_rdata = special_rd ? (special_addr ^ 8'h5A) : junk_r;
   assign code_rdata  = code_rd ? (code_addr[7:0] ^ 8'hA5) : junk_r;
   assign flash_rdata = flash_rd ? ({1'b0, flash_addr} ^ 8'hC3) : ~junk_r;
endmodule
`default_nettype wire

//--- data_mem_map.sv
`timescale 1ns/1ns
`default_nettype none
module data_mem_map
#(
   parameter int CODE_SIZE  = 16384,
   parameter int FLASH_SIZE = 128
)
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   // request from the execution core
   input  wire logic                   req_valid,
   input  wire data_mem_pkg::mem_op_t  req_op,
   input  wire logic                   req_write,
   input  wire logic [15:0]            req_addr,
   input  wire logic [2:0]             req_bit,
   input  wire logic [7:0]             req_wdata,
   input  wire logic                   ptr_sel,
   // status word bank select and stack pointer load
   input  wire logic [7:0]             program_status_word,
   input  wire logic                   stack_load,
   input  wire logic [7:0]             stack_load_val,
   // special register port, direct and bit access
   output logic                        special_rd,
   output logic                        special_wr,
   output logic [7:0]                  special_addr,
   output logic [7:0]                  special_wdata,
   input  wire logic [7:0]             special_rdata,
   // program memory and data flash read port
   output logic                        code_rd,
   output logic [13:0]                 code_addr,
   input  wire logic [7:0]             code_rdata,
   output logic                        flash_rd,
   output logic [6:0]                  flash_addr,
   input  wire logic [7:0]             flash_rdata,
   // answer
   output logic                        rsp_valid,
   output logic [7:0]                  rsp_rdata,
   output logic                        rsp_bit,
   output logic [7:0]                  stack_pointer,
   output logic                        bad_access
);
   import data_mem_pkg::*;

   // code and flash windows share one address space, so sizes are bounded
   if (CODE_SIZE > CODE_BYTES || CODE_SIZE < 1 || FLASH_SIZE != FLASH_BYTES)
   begin : g_size_check
      $error("unsupported memory size");
   end

   logic [7:0] scratch [0:SCRATCH_BYTES-1];
   logic [7:0] aux     [0:AUX_BYTES-1];
   logic [7:0] stack_r;
   logic [1:0] bank_select_bits;
   logic [7:0] indirect_pointer_zero;
   logic [7:0] indirect_pointer_one;
   logic [7:0] ptr;
   logic [7:0] ram_addr;
   logic [7:0] bit_byte;
   logic       is_special;
   logic       ram_we;
   logic [7:0] ram_wd;
   logic [7:0] stack_inc;

   function automatic logic [7:0] reg_addr(input logic [1:0] b, input logic [2:0] n);
      reg_addr = {3'b000, b, n};
   endfunction

   // bit address: low half scratch-pad, high half special registers
   function automatic logic [7:0] bit_byte_of(input logic [7:0] a);
      if (a[7])
         bit_byte_of = {a[7:3], 3'b000};
      else
         bit_byte_of = BIT_RAM_BASE + {4'h0, a[6:3]};
   endfunction

   // bit write: rebuild the byte around one changed bit
   function automatic logic [7:0] merge_bit(input logic [7:0] v, input logic [2:0] pos,
                                            input logic bit_val);
      merge_bit      = v;
      merge_bit[pos] = bit_val;
   endfunction

   assign bank_select_bits      = program_status_word[BANK_SEL_LSB +: 2];
   assign indirect_pointer_zero = scratch[reg_addr(bank_select_bits, 3'd0)];
   assign indirect_pointer_one  = scratch[reg_addr(bank_select_bits, 3'd1)];
   assign ptr    = ptr_sel ? indirect_pointer_one : indirect_pointer_zero;
   assign stack_inc = stack_r + 8'h01;
   assign bit_byte = bit_byte_of(req_addr[7:0]);
   assign stack_pointer = stack_r;

   // address and target decode
   always_comb
   begin
      ram_addr = 8'h00;
      is_special = 1'b0;
      case (req_op)
         OP_DIRECT:
         begin
            ram_addr   = req_addr[7:0];
            is_special = (req_addr[7:0] >= SPECIAL_BASE);
         end
         OP_INDIR: ram_addr = ptr;
         OP_REG:   ram_addr = reg_addr(bank_select_bits, req_addr[2:0]);
         OP_BIT:
         begin
            ram_addr   = bit_byte;
            is_special = (req_addr[7:0] >= SPECIAL_BASE);
         end
         OP_PUSH:  ram_addr = stack_inc;
         OP_POP:   ram_addr = stack_r;
         default:  ram_addr = 8'h00;
      endcase
   end

   // scratch-pad write, bit ops read-modify-write the held byte
   always_comb
   begin
      ram_we = 1'b0;
      ram_wd = req_wdata;
      if (req_valid && !is_special)
      begin
         case (req_op)
            OP_DIRECT, OP_INDIR, OP_REG: ram_we = req_write;
            OP_BIT:
            begin
               ram_we = req_write;
               ram_wd = merge_bit(scratch[ram_addr], req_bit, req_wdata[0]);
            end
            OP_PUSH: ram_we = 1'b1;
            default: ram_we = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (ram_we)
         scratch[ram_addr] <= ram_wd;
   end

   always_ff @(posedge clk)
   begin
      if (req_valid && req_op == OP_AUX && req_write && req_addr <= AUX_HI)
         aux[req_addr[7:0]] <= req_wdata;
   end

   // stack pointer; a load wins over a push or pop in the same cycle
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         stack_r <= STACK_RESET;
      else if (stack_load)
         stack_r <= stack_load_val;
      else if (req_valid && req_op == OP_PUSH)
         stack_r <= stack_inc;
      else if (req_valid && req_op == OP_POP)
         stack_r <= stack_r - 8'h01;
   end

   // special register strobes, combinational handshake
   always_comb
   begin
      special_rd    = req_valid && is_special && !(req_write && req_op == OP_DIRECT);
      special_wr    = req_valid && is_special && req_write;
      special_addr  = (req_op == OP_BIT) ? bit_byte : req_addr[7:0];
      // bit writes read the register and hand back the merged byte
      special_wdata = (req_op == OP_BIT) ? merge_bit(special_rdata, req_bit, req_wdata[0])
                                         : req_wdata;
      code_rd  = req_valid && req_op == OP_CODE && req_addr < 16'(CODE_SIZE);
      code_addr = req_addr[13:0];
      // flash is read only here; programming goes through its own registers
      flash_rd   = req_valid && req_op == OP_CODE && req_addr >= FLASH_BASE
                   && req_addr < FLASH_BASE + 16'(FLASH_SIZE);
      flash_addr = req_addr[6:0];
   end

   // answer, one cycle after request; memories and ports sampled at request
   logic [7:0] rd_nxt;
   logic       bad_nxt;
   always_comb
   begin
      rd_nxt  = scratch[ram_addr];
      bad_nxt = 1'b0;
      case (req_op)
         OP_DIRECT: rd_nxt = is_special ? special_rdata : scratch[ram_addr];
         OP_BIT:    rd_nxt = {7'h00, (is_special ? special_rdata[req_bit]
                                                 : scratch[ram_addr][req_bit])};
         OP_AUX:
         begin
            rd_nxt  = aux[req_addr[7:0]];
            bad_nxt = req_addr > AUX_HI;
         end
         OP_CODE:
         begin
            rd_nxt  = flash_rd ? flash_rdata : code_rdata;
            bad_nxt = !(code_rd || flash_rd);
         end
         OP_NONE:   bad_nxt = 1'b0;
         default:   rd_nxt = scratch[ram_addr];
      endcase
      if (bad_nxt)
         rd_nxt = 8'h00;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rsp_valid  <= 1'b0;
         rsp_rdata  <= 8'h00;
         rsp_bit    <= 1'b0;
         bad_access <= 1'b0;
      end
      else
      begin
         rsp_valid  <= req_valid && req_op != OP_NONE;
         rsp_rdata  <= rd_nxt;
         rsp_bit    <= req_valid && req_op == OP_BIT;
         bad_access <= req_valid && bad_nxt;
      end
   end

   // checks
   property p_stack_push;
      @(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_PUSH && !stack_load) |=> (stack_r == $past(stack_r) + 8'h01);
   endproperty
   a_stack_push: assert property (p_stack_push) else $error("push missed pointer");

   property p_stack_pop;
      @(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_POP && !stack_load) |=> (stack_r == $past(stack_r) - 8'h01);
   endproperty
   a_stack_pop: assert property (p_stack_pop) else $error("pop missed pointer");

   property p_stack_load;
      @(posedge clk) disable iff (sys_rst)
      stack_load |=> (stack_r == $past(stack_load_val));
   endproperty
   a_stack_load: assert property (p_stack_load) else $error("pointer load lost");

   property p_push_write;
      @(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_PUSH) |=> (scratch[$past(stack_inc)] == $past(req_wdata));
   endproperty
   a_push_write: assert property (p_push_write) else $error("push byte misplaced");

   property p_indir_ram;
      @(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_INDIR) |-> !special_rd && !special_wr;
   endproperty
   a_indir_ram: assert property (p_indir_ram) else $error("indirect hit special");

   property p_direct_wr;
      @(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_DIRECT && req_addr[7] && req_write) |-> special_wr;
   endproperty
   a_direct_wr: assert property (p_direct_wr) else $error("direct write missed");

   property p_special_bit_addr;
      @(posedge clk) disable iff (sys_rst)
      (special_rd && req_op == OP_BIT) |-> (special_addr[2:0] == 3'b000);
   endproperty
   a_special_bit_addr: assert property (p_special_bit_addr) else $error("bad bit addr");

   property p_special_bit_wr;
      @(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_BIT && req_addr[7] && req_write)
         |-> (special_wr && special_wdata[req_bit] == req_wdata[0]);
   endproperty
   a_special_bit_wr: assert property (p_special_bit_wr) else $error("bit write lost");

   property p_bit_ram_range;
      @(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_BIT && !req_addr[7])
         |-> (ram_addr >= BIT_RAM_BASE && ram_addr <= BIT_RAM_TOP);
   endproperty
   a_bit_ram_range: assert property (p_bit_ram_range) else $error("bit ram out of range");

   property p_reg_map;
      @(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_REG)
         |-> (ram_addr == {3'b000, program_status_word[4:3], req_addr[2:0]});
   endproperty
   a_reg_map: assert property (p_reg_map) else $error("register bank map wrong");

   property p_flash_path;
      @(posedge clk) disable iff (sys_rst)
      flash_rd |-> (req_op == OP_CODE && !code_rd);
   endproperty
   a_flash_path: assert property (p_flash_path) else $error("flash read path wrong");

   property p_answer;
      @(posedge clk) disable iff (sys_rst)
      (req_valid && req_op != OP_NONE) |=> rsp_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("answer missing");

   c_push_pop: cover property (@(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_PUSH) ##1 (req_valid && req_op == OP_POP));
   c_bit_special: cover property (@(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_BIT && req_addr[7]));
   c_flash: cover property (@(posedge clk) disable iff (sys_rst) flash_rd);
   c_bank3: cover property (@(posedge clk) disable iff (sys_rst)
      (req_valid && req_op == OP_REG && bank_select_bits == 2'b11));
endmodule
`default_nettype wire

//--- data_mem_pkg.sv
// Notes on behaviour
// - four banks of eight byte registers
// - bank chosen by status word select bits
// - first two bank registers serve as pointers
// - bytes 20h-2Fh byte and bit accessible
// - special registers at x0/x8 bit accessible
// - special registers 80-FFh direct only
// - scratch-pad RAM direct and indirect access
// - bit versus byte chosen by instruction type
// - stack pointer resets to 07h, loadable
// - push increments pointer, then writes
// - pop reads first, then decrements
// - calls and interrupts push return address
// - stack may start anywhere in RAM
// - auxiliary RAM spans 0000H to 00FFH
// - program memory up to 16K, constant reads
// - 128-byte data flash, 16-byte pages, read path
`default_nettype none
package data_mem_pkg;
   localparam logic [7:0] STACK_RESET   = 8'h07;
   localparam logic [7:0] BIT_RAM_BASE  = 8'h20;
   localparam logic [7:0] BIT_RAM_TOP   = 8'h2F;
   localparam logic [7:0] SPECIAL_BASE  = 8'h80;
   localparam int         BANK_SEL_LSB  = 3;
   localparam int         REG_BANKS     = 4;
   localparam int         REGS_PER_BANK = 8;
   localparam int         SCRATCH_BYTES = 256;
   localparam int         AUX_BYTES     = 256;
   localparam int         CODE_BYTES    = 16384;
   localparam int         FLASH_BYTES   = 128;
   localparam int         FLASH_PAGE    = 16;
   localparam logic [15:0] AUX_LO       = 16'h0000;
   localparam logic [15:0] AUX_HI       = 16'h00FF;
   localparam logic [15:0] FLASH_BASE   = 16'h4000;
   // operation codes from the execution core
   typedef enum logic [3:0] {
      OP_NONE   = 4'h0,
      OP_DIRECT = 4'h1,
      OP_INDIR  = 4'h2,
      OP_REG    = 4'h3,
      OP_BIT    = 4'h4,
      OP_PUSH   = 4'h5,
      OP_POP    = 4'h6,
      OP_AUX    = 4'h7,
      OP_CODE   = 4'h8
   } mem_op_t;
endpackage
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import data_mem_pkg::*;
   logic        clk, sys_rst, req_valid, req_write, ptr_sel, stack_load;
   mem_op_t     req_op;
   logic [15:0] req_addr;
   logic [2:0]  req_bit;
   logic [7:0]  req_wdata, program_status_word, stack_load_val;
   logic        special_rd, special_wr, code_rd, flash_rd, rsp_valid, rsp_bit, bad_access;
   logic [7:0]  special_addr, special_wdata, special_rdata;
   logic [7:0]  code_rdata, flash_rdata, rsp_rdata, stack_pointer;
   logic [13:0] code_addr;
   logic [6:0]  flash_addr;
   int          fails, check_count;
   int          cyc = 0;
   data_mem_map dut_u (.clk, .sys_rst, .req_valid, .req_op, .req_write, .req_addr,
      .req_bit, .req_wdata, .ptr_sel, .program_status_word, .stack_load, .stack_load_val,
      .special_rd, .special_wr, .special_addr, .special_wdata, .special_rdata,
      .code_rd, .code_addr, .code_rdata,
      .flash_rd, .flash_addr, .flash_rdata, .rsp_valid, .rsp_rdata, .rsp_bit,
      .stack_pointer, .bad_access);
   core_side_model model_u (.clk, .special_rd, .special_addr, .special_rdata, .code_rd,
      .code_addr, .code_rdata, .flash_rd, .flash_addr, .flash_rdata);
   always #5 clk = ~clk;
   task close_out;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held from just after one edge; comb strobes looked at mid-cycle
   task go(input mem_op_t op, input logic w, input logic [15:0] a, input logic [7:0] d);
      req_valid = 1'b1;
      req_op = op;
      req_write = w;
      req_addr = a;
      req_bit = a[2:0];
      req_wdata = d;
      @(negedge clk);
   endtask
   task nx;
      @(posedge clk);
      #1;
   endtask
   task stop;
      req_valid = 1'b0;
      nx;
   endtask
   task t_banks;
      for (int b = 0; b < 4; b++)
      begin
         program_status_word = 8'(b << 3);
         go(OP_REG, 1'b1, 16'(b + 1), 8'(8'hA0 + b));
         nx;
      end
      program_status_word = 8'h00;
      for (int b = 0; b < 4; b++)
      begin
         go(OP_DIRECT, 1'b0, 16'(b * 9 + 1), 8'h00);
         nx;
         chk(rsp_rdata, 16'(8'hA0 + b));
      end
      program_status_word = 8'h18;
      go(OP_REG, 1'b0, 16'h0004, 8'h00);
      nx;
      chk({rsp_valid, rsp_rdata}, 16'h01A3);
      stop;
   endtask
   task t_ptrs;
      program_status_word = 8'h10;
      go(OP_REG, 1'b1, 16'h0000, 8'hC5);
      nx;
      go(OP_REG, 1'b1, 16'h0001, 8'h41);
      nx;
      go(OP_INDIR, 1'b1, 16'h0000, 8'h5E);
      chk(special_wr, 16'h0000);
      nx;
      ptr_sel = 1'b1;
      go(OP_INDIR, 1'b1, 16'h0000, 8'h6F);
      nx;
      ptr_sel = 1'b0;
      go(OP_DIRECT, 1'b0, 16'h0041, 8'h00);
      nx;
      chk(rsp_rdata, 16'h006F);
      go(OP_INDIR, 1'b0, 16'h0000, 8'h00);
      chk(special_rd, 16'h0000);
      nx;
      chk(rsp_rdata, 16'h005E);
      go(OP_DIRECT, 1'b0, 16'h0085, 8'h00);
      chk({special_rd, special_addr}, 16'h0185);
      nx;
      chk(rsp_rdata, 16'h00DF);
      go(OP_DIRECT, 1'b1, 16'h0085, 8'h77);
      chk({special_wr, special_rd, special_wdata}, 16'h0277);
      nx;
      stop;
   endtask
   task t_bits;
      program_status_word = 8'h00;
      go(OP_DIRECT, 1'b1, 16'h0021, 8'h00);
      nx;
      go(OP_BIT, 1'b1, 16'h000B, 8'h01);
      nx;
      go(OP_DIRECT, 1'b0, 16'h0021, 8'h00);
      nx;
      chk({rsp_bit, rsp_rdata}, 16'h0008);
      go(OP_BIT, 1'b0, 16'h000B, 8'h00);
      nx;
      chk({rsp_bit, rsp_rdata[0]}, 16'h0003);
      go(OP_BIT, 1'b0, 16'h0093, 8'h00);
      chk({special_rd, special_addr}, 16'h0190);
      nx;
      chk(rsp_rdata[0], 16'h0001);
      go(OP_BIT, 1'b1, 16'h0093, 8'h00);
      chk({special_wr, special_wdata}, 16'h01C2);
      nx;
      stop;
   endtask
   task t_stack;
      stack_load = 1'b1;
      stack_load_val = 8'h7E;
      nx;
      stack_load = 1'b0;
      chk(stack_pointer, 16'h007E);
      go(OP_PUSH, 1'b0, 16'h0000, 8'h34);
      nx;
      chk(stack_pointer, 16'h007F);
      go(OP_PUSH, 1'b0, 16'h0000, 8'h12);
      nx;
      chk(stack_pointer, 16'h0080);
      go(OP_DIRECT, 1'b0, 16'h007F, 8'h00);
      nx;
      chk(rsp_rdata, 16'h0034);
      go(OP_POP, 1'b0, 16'h0000, 8'h00);
      nx;
      chk({rsp_rdata, stack_pointer}, 16'h127F);
      go(OP_POP, 1'b0, 16'h0000, 8'h00);
      nx;
      chk({rsp_rdata, stack_pointer}, 16'h347E);
      stop;
   endtask
   task t_ext;
      go(OP_AUX, 1'b1, 16'h00FF, 8'h9C);
      nx;
      go(OP_AUX, 1'b1, 16'h01FF, 8'h11);
      nx;
      chk(bad_access, 16'h0001);
      go(OP_AUX, 1'b0, 16'h00FF, 8'h00);
      nx;
      chk({bad_access, rsp_rdata}, 16'h009C);
      go(OP_CODE, 1'b0, 16'h3FFF, 8'h00);
      chk({code_rd, code_addr}, 16'h7FFF);
      nx;
      chk(rsp_rdata, 16'h005A);
      go(OP_CODE, 1'b0, 16'h407F, 8'h00);
      chk({flash_rd, flash_addr}, 16'h00FF);
      nx;
      chk(rsp_rdata, 16'h00BC);
      go(OP_CODE, 1'b0, 16'h4080, 8'h00);
      chk({code_rd, flash_rd}, 16'h0000);
      nx;
      chk(bad_access, 16'h0001);
      stop;
      chk({rsp_valid, bad_access}, 16'h0000);
   endtask
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      req_valid = 1'b0;
      req_op = OP_NONE;
      req_write = 1'b0;
      req_addr = 16'h0000;
      req_bit = 3'h0;
      req_wdata = 8'h00;
      ptr_sel = 1'b0;
      program_status_word = 8'h00;
      stack_load = 1'b0;
      stack_load_val = 8'h00;
      fails = 0;
      check_count = 0;
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      chk({rsp_valid, stack_pointer}, 16'h0007);
      t_banks;
      t_ptrs;
      t_bits;
      t_stack;
      t_ext;
      close_out;
   end
   // run needs 43 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         $display("MISMATCH t=%0t cycles=%h limit=%h", $time, cyc, 2000);
         fails++;
         close_out;
      end
   end
endmodule
`default_nettype wire
